// [design/lnc_map.vh]
`ifndef LNC_MAP_VH
`define LNC_MAP_VH

// ****************************************
// direct register selects
// ****************************************
`define LNC_SFR_CONF 2'h0
`define LNC_SFR_INDEX 2'h1
`define LNC_SFR_WINDOW 2'h2

// ****************************************
// indirect map
// ****************************************
`define LNC_IX_DATA_TOP 8'h07
`define LNC_IX_CTRL 8'h08
`define LNC_IX_STAT 8'h09
`define LNC_IX_ERR 8'h0A
`define LNC_IX_SIZE 8'h0B
`define LNC_IX_DIV 8'h0C
`define LNC_IX_MUL 8'h0D
`define LNC_IX_ID 8'h0E

// ****************************************
// field positions
// ****************************************
`define LNC_CONF_EN 7
`define LNC_CONF_MASTER 6
`define LNC_CONF_AUTO 5
`define LNC_CTRL_START 0
`define LNC_CTRL_RSTERR 2
`define LNC_CTRL_RSTINT 3
`define LNC_CTRL_DACK 4
`define LNC_CTRL_TXRX 5
`define LNC_CTRL_STOP 7
`define LNC_CTRL_KEEP 8'h60
`define LNC_SIZE_ENH 7
`define LNC_ERR_BIT 3'd0
`define LNC_ERR_CKS 3'd1
`define LNC_ERR_TMO 3'd2
`define LNC_ERR_SYNC 3'd3
`define LNC_ERR_PAR 3'd4
`define LNC_ERR_FRM 3'd5

// ****************************************
// reset values and timing counts
// ****************************************
`define LNC_RST_BYTE 8'h00
`define LNC_BRK_BITS 4'hD
`define LNC_BRK_MIN 4'hB
`define LNC_RSP_TMO 4'hF
`define LNC_SYNC_BYTE 8'h55
`define LNC_SYNC_FALLS 3'h4
`endif

// [design/lnc_rx_sync.v]
`timescale 1ns/10ps
// three-stage catcher for the bus receive pin
module lnc_rx_sync (
	// clock and reset
	input wire ref_clk,
	input wire resetn,
	// raw pin and clean level
	input wire pin,
	output reg level_q
);
	reg s1_q; // first stage, read only by s2_q
	reg s2_q;
	reg s3_q;

	// level moves only once stages two and three agree
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
			s3_q <= 1'b1;
			level_q <= 1'b1;
		end else begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				level_q <= s3_q;
			end
		end
	end
endmodule

// [design/lnc_baud.v]
`timescale 1ns/10ps
// bit timer built from prescale, divide and multiply counters
module lnc_baud #(
	parameter DIV_W = 9
) (
	// clock and reset
	input wire ref_clk,
	input wire resetn,
	// restart aligns a bit period to a bus edge
	input wire restart,
	// rate factors, wide enough for pre 0-3, mul 0-31, div up to 511
	input wire [1:0] pre,
	input wire [4:0] mul,
	input wire [DIV_W-1:0] div,
	// bit timing pulses
	output reg bit_mid,
	output reg bit_end
);
	reg [3:0] pre_cnt_q; // up to 2^(pre+1) clocks
	reg [DIV_W-1:0] div_cnt_q;
	reg [4:0] mul_cnt_q;
	reg [1:0] pre_l_q; // factors held for the running bit
	reg [4:0] mul_l_q;
	reg [DIV_W-1:0] div_l_q;
	wire [3:0] pre_top = (4'd2 << pre_l_q) - 4'd1;
	wire pre_last = (pre_cnt_q == pre_top);
	// a zero divider acts as one so the timer never stalls
	wire div_last = (div_cnt_q + {{(DIV_W-1){1'b0}}, 1'b1} >= div_l_q);
	wire mul_last = (mul_cnt_q == mul_l_q);
	wire [3:0] pre_half = pre_top >> 1; // last clock of the first half of a tick
	wire mul_half = (mul_cnt_q == (mul_l_q >> 1));
	// half a bit ends on a tick edge when mul+1 is even, else inside the middle tick
	wire mid_now = mul_l_q[0] ? (pre_last && div_last && mul_half) :
		div_l_q[0] ? ((pre_cnt_q == pre_half) && (div_cnt_q == (div_l_q >> 1)) && mul_half) :
		(pre_last && (div_cnt_q + {{(DIV_W-1){1'b0}}, 1'b1} == (div_l_q >> 1)) && mul_half);

	// nested counting gives clock/(2^(pre+1)*div*(mul+1)) per bit
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pre_cnt_q <= 4'd0;
			div_cnt_q <= {DIV_W{1'b0}};
			mul_cnt_q <= 5'd0;
			pre_l_q <= 2'd0;
			mul_l_q <= 5'd0;
			div_l_q <= {DIV_W{1'b0}};
			bit_mid <= 1'b0;
			bit_end <= 1'b0;
		end else if (restart) begin
			// restart and bit pulses are both registered: start two clocks in,
			// so the first bit after a restart is one period like the rest
			pre_cnt_q <= (pre == 2'd0) ? 4'd0 : 4'd2;
			div_cnt_q <= (pre == 2'd0) ? {{(DIV_W-1){1'b0}}, 1'b1} : {DIV_W{1'b0}};
			mul_cnt_q <= 5'd0;
			pre_l_q <= pre;
			mul_l_q <= mul;
			div_l_q <= div;
			bit_mid <= 1'b0;
			bit_end <= 1'b0;
		end else begin
			// middle of the bit, never on the same clock as its end
			bit_mid <= mid_now;
			bit_end <= 1'b0;
			pre_cnt_q <= pre_last ? 4'd0 : pre_cnt_q + 4'd1;
			if (pre_last) begin
				div_cnt_q <= div_last ? {DIV_W{1'b0}} : div_cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
				if (div_last) begin
					mul_cnt_q <= mul_last ? 5'd0 : mul_cnt_q + 5'd1;
					if (mul_last) begin
						// new factors only at a bit boundary
						bit_end <= 1'b1;
						pre_l_q <= pre;
						mul_l_q <= mul;
						div_l_q <= div;
					end
				end
			end
		end
	end
endmodule

// [design/lnc_top.v]
`timescale 1ns/10ps
`include "lnc_map.vh"
// bus node controller: master or slave, frames done in hardware
module lnc_top #(
	parameter DIV_W = 9
) (
	// clock and reset
	input wire ref_clk,
	input wire resetn,
	// direct register port
	input wire [1:0] sfr_addr,
	input wire sfr_wr,
	input wire [7:0] sfr_wdata,
	output reg [7:0] sfr_rdata_q,
	// bus pins
	input wire lin_rx,
	output reg lin_tx_q,
	// interrupt request level
	output reg irq_q
);
	// ****************************************
	// states and phases
	// ****************************************
	localparam S_IDLE = 4'd0;
	localparam S_BRK = 4'd1; // master drives break
	localparam S_DEL = 4'd2; // break delimiter
	localparam S_BYTE = 4'd3; // one byte on the wire
	localparam S_RXW = 4'd4; // waiting for a start edge
	localparam S_SBRK = 4'd5; // slave timing a break
	localparam S_SYNC = 4'd6; // slave measuring sync field
	localparam S_WACK = 4'd7; // slave waits for software
	localparam P_SYNC = 2'd0;
	localparam P_ID = 2'd1;
	localparam P_DATA = 2'd2;
	localparam P_CKS = 2'd3;

	// ****************************************
	// registers
	// ****************************************
	reg [7:0] conf_q; // node_configuration
	reg [7:0] index_q; // indirect_index
	reg [7:0] ctrl_q; // stored transfer_control bits
	reg [7:0] size_q; // frame_size_checksum
	reg [7:0] divlo_q; // rate_divider_low
	reg [7:0] mul_q; // rate_factors
	reg [5:0] id_q;
	reg [7:0] err_q;
	reg done_q;
	reg int_q;
	reg dreq_q; // identifier received, waiting for software
	reg [7:0] data_q [0:7]; // response bytes
	reg [3:0] state_q;
	reg [1:0] phase_q;
	reg [3:0] bit_idx_q;
	reg [3:0] cnt_q;
	reg [7:0] shf_q; // transmit shifter
	reg [7:0] rxs_q; // receive shifter
	reg [2:0] byte_cnt_q;
	reg [7:0] cks_q;
	reg [19:0] meas_q; // sync field length in clocks
	reg [DIV_W-1:0] adiv_q; // divider learned from sync
	reg is_tx_q; // this byte is driven by us
	reg resp_tx_q; // we send the response
	reg go_q; // restart pulse for the bit timer
	reg rx_prev_q;
	wire rx_lvl;
	wire bit_mid;
	wire bit_end;
	reg [7:0] ind_rd;
	integer i;

	// ****************************************
	// helpers
	// ****************************************
	// add with end-around carry
	function [7:0] f_csum;
		input [7:0] s;
		input [7:0] b;
		reg [8:0] t;
		begin
			t = {1'b0, s} + {1'b0, b};
			f_csum = t[7:0] + {7'd0, t[8]};
		end
	endfunction

	// identifier with its two parity bits
	function [7:0] f_pid;
		input [5:0] d;
		begin
			f_pid = {~(d[1] ^ d[3] ^ d[4] ^ d[5]), d[0] ^ d[1] ^ d[2] ^ d[4], d};
		end
	endfunction

	// data length, code 0xF takes it from the identifier
	function [3:0] f_len;
		input [7:0] sz;
		input [5:0] d;
		begin
			if (sz[3:0] == 4'hF) begin
				case (d[5:4])
					2'd2: f_len = 4'd4;
					2'd3: f_len = 4'd8;
					default: f_len = 4'd2;
				endcase
			end else if (sz[3:0] == 4'h0) begin
				f_len = 4'd1;
			end else if (sz[3:0] > 4'h8) begin
				f_len = 4'd8;
			end else begin
				f_len = sz[3:0];
			end
		end
	endfunction

	wire master = conf_q[`LNC_CONF_MASTER];
	wire auto_on = conf_q[`LNC_CONF_AUTO] & ~master;
	wire win_wr = sfr_wr && (sfr_addr == `LNC_SFR_WINDOW);
	wire ctrl_wr = win_wr && (index_q == `LNC_IX_CTRL);
	wire fall = rx_prev_q & ~rx_lvl;
	wire bit_mid_v = bit_mid & ~go_q;
	wire bit_end_v = bit_end & ~go_q;
	// frames with diagnostic identifiers always use the classic sum
	wire enh = size_q[`LNC_SIZE_ENH] && (id_q[5:2] != 4'hF);
	wire [7:0] cks0 = enh ? f_pid(id_q) : 8'h00;
	wire [3:0] len = f_len(size_q, id_q);
	wire [2:0] nxt = byte_cnt_q + 3'd1;
	wire [7:0] sum_now = f_csum(cks_q, rxs_q);
	wire [19:0] meas_sh = meas_q >> ({1'b0, mul_q[7:6]} + 3'd4);
	// learned divider replaces programmed one in automatic mode
	wire use_auto = auto_on && (adiv_q != {DIV_W{1'b0}});
	wire [DIV_W-1:0] div_sel = use_auto ? adiv_q : {mul_q[0], divlo_q};

	lnc_rx_sync u_sync (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.pin(lin_rx),
		.level_q(rx_lvl)
	);

	// factors come from the two rate registers, but a learned divider brings mul 0
	lnc_baud #(.DIV_W(DIV_W)) u_baud (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.restart(go_q),
		.pre(mul_q[7:6]),
		.mul(use_auto ? 5'd0 : mul_q[5:1]),
		.div(div_sel),
		.bit_mid(bit_mid),
		.bit_end(bit_end)
	);

	// ****************************************
	// indirect read mux
	// ****************************************
	// window read follows the index, holes read zero
	always @* begin
		ind_rd = 8'h00;
		if (index_q <= `LNC_IX_DATA_TOP) begin
			ind_rd = data_q[index_q[2:0]];
		end else begin
			case (index_q)
				`LNC_IX_CTRL: ind_rd = ctrl_q;
				// status readable for polling
				`LNC_IX_STAT: ind_rd = {state_q != S_IDLE, 2'b00, dreq_q, int_q,
					err_q != 8'h00, 1'b0, done_q};
				`LNC_IX_ERR: ind_rd = err_q;
				`LNC_IX_SIZE: ind_rd = size_q;
				`LNC_IX_DIV: ind_rd = divlo_q;
				`LNC_IX_MUL: ind_rd = mul_q;
				`LNC_IX_ID: ind_rd = {2'b00, id_q};
				default: ind_rd = 8'h00;
			endcase
		end
	end

	// ****************************************
	// frame tasks
	// ****************************************
	// start one byte, driven (tx) or awaited (rx)
	task launch;
		input tx;
		input [7:0] b;
		begin
			is_tx_q <= tx;
			shf_q <= b;
			bit_idx_q <= 4'd0;
			cnt_q <= 4'd0;
			if (tx) begin
				state_q <= S_BYTE;
				go_q <= 1'b1;
				lin_tx_q <= 1'b0;
			end else begin
				state_q <= S_RXW;
			end
		end
	endtask

	task fail;
		input [2:0] n;
		begin
			err_q[n] <= 1'b1;
			int_q <= 1'b1;
			state_q <= S_IDLE;
			lin_tx_q <= 1'b1;
		end
	endtask

	// ****************************************
	// registers and frame engine
	// ****************************************
	// software writes come first so hardware sets in the same cycle win
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			conf_q <= `LNC_RST_BYTE;
			index_q <= `LNC_RST_BYTE;
			ctrl_q <= `LNC_RST_BYTE;
			size_q <= `LNC_RST_BYTE;
			divlo_q <= `LNC_RST_BYTE;
			mul_q <= `LNC_RST_BYTE;
			id_q <= 6'd0;
			err_q <= `LNC_RST_BYTE;
			done_q <= 1'b0;
			int_q <= 1'b0;
			dreq_q <= 1'b0;
			for (i = 0; i < 8; i = i + 1) begin
				data_q[i] <= `LNC_RST_BYTE;
			end
			state_q <= S_IDLE;
			phase_q <= P_SYNC;
			bit_idx_q <= 4'd0;
			cnt_q <= 4'd0;
			shf_q <= 8'h00;
			rxs_q <= 8'h00;
			byte_cnt_q <= 3'd0;
			cks_q <= 8'h00;
			meas_q <= 20'd0;
			adiv_q <= {DIV_W{1'b0}};
			is_tx_q <= 1'b0;
			resp_tx_q <= 1'b0;
			go_q <= 1'b0;
			rx_prev_q <= 1'b1;
			lin_tx_q <= 1'b1;
			irq_q <= 1'b0;
			sfr_rdata_q <= 8'h00;
		end else begin
			go_q <= 1'b0;
			rx_prev_q <= rx_lvl;
			irq_q <= int_q;
			// read data follows the address one cycle later
			case (sfr_addr)
				`LNC_SFR_CONF: sfr_rdata_q <= conf_q;
				`LNC_SFR_INDEX: sfr_rdata_q <= index_q;
				`LNC_SFR_WINDOW: sfr_rdata_q <= ind_rd;
				default: sfr_rdata_q <= 8'h00;
			endcase
			// enable bit sticks once set
			if (sfr_wr && sfr_addr == `LNC_SFR_CONF) begin
				conf_q <= {conf_q[`LNC_CONF_EN] | sfr_wdata[7], sfr_wdata[6:0]};
			end
			if (sfr_wr && sfr_addr == `LNC_SFR_INDEX) begin
				index_q <= sfr_wdata;
			end
			// window writes land in the indexed register
			if (win_wr) begin
				if (index_q <= `LNC_IX_DATA_TOP) begin
					data_q[index_q[2:0]] <= sfr_wdata;
				end
				case (index_q)
					`LNC_IX_SIZE: size_q <= sfr_wdata;
					`LNC_IX_DIV: divlo_q <= sfr_wdata;
					`LNC_IX_MUL: mul_q <= sfr_wdata;
					`LNC_IX_ID: id_q <= sfr_wdata[5:0];
					default: ;
				endcase
			end
			if (ctrl_wr) begin
				ctrl_q <= sfr_wdata & `LNC_CTRL_KEEP;
				if (sfr_wdata[`LNC_CTRL_RSTINT]) begin
					int_q <= 1'b0;
					done_q <= 1'b0;
				end
				if (sfr_wdata[`LNC_CTRL_RSTERR]) begin
					err_q <= 8'h00;
				end
			end

			// bit streaming and frame sequencing
			if (!conf_q[`LNC_CONF_EN]) begin
				state_q <= S_IDLE;
				lin_tx_q <= 1'b1;
			end else begin
				case (state_q)
					S_IDLE: begin
						if (master && ctrl_wr && sfr_wdata[`LNC_CTRL_START]) begin
							// master schedules a frame
							resp_tx_q <= sfr_wdata[`LNC_CTRL_TXRX];
							done_q <= 1'b0;
							state_q <= S_BRK;
							cnt_q <= 4'd0;
							go_q <= 1'b1;
							lin_tx_q <= 1'b0;
						end else if (!master && fall) begin
							state_q <= S_SBRK;
							cnt_q <= 4'd0;
							go_q <= 1'b1;
						end
					end
					S_BRK: begin
						if (bit_end_v) begin
							if (cnt_q == `LNC_BRK_BITS - 4'd1) begin
								lin_tx_q <= 1'b1;
								state_q <= S_DEL;
							end else begin
								cnt_q <= cnt_q + 4'd1;
							end
						end
					end
					S_DEL: begin
						if (bit_end_v) begin
							phase_q <= P_SYNC;
							launch(1'b1, `LNC_SYNC_BYTE);
						end
					end
					S_SBRK: begin
						if (rx_lvl) begin
							if (cnt_q >= `LNC_BRK_MIN) begin
								phase_q <= P_SYNC;
								cnt_q <= 4'd0;
								meas_q <= 20'd0;
								state_q <= auto_on ? S_SYNC : S_RXW;
							end else begin
								state_q <= S_IDLE;
							end
						end else if (bit_end_v && cnt_q != 4'hF) begin
							cnt_q <= cnt_q + 4'd1;
						end
					end
					S_SYNC: begin
						// time from sync start edge to its fifth falling edge is 8 bits
						if (cnt_q != 4'd0) begin
							meas_q <= meas_q + 20'd1;
						end
						if (meas_q == 20'hF_FFFF) begin
							fail(`LNC_ERR_SYNC);
						end else if (fall) begin
							cnt_q <= cnt_q + 4'd1;
							if (cnt_q[2:0] == `LNC_SYNC_FALLS) begin
								adiv_q <= (meas_sh[19:DIV_W] != 0) ? {DIV_W{1'b1}} :
									meas_sh[DIV_W-1:0];
								phase_q <= P_ID;
								cnt_q <= 4'd0;
								state_q <= S_RXW;
							end
						end
					end
					S_RXW: begin
						if (fall) begin
							state_q <= S_BYTE;
							bit_idx_q <= 4'd0;
							go_q <= 1'b1;
						end else if (bit_end_v) begin
							if (cnt_q == `LNC_RSP_TMO) begin
								fail(`LNC_ERR_TMO);
							end else begin
								cnt_q <= cnt_q + 4'd1;
							end
						end
					end
					S_WACK: begin
						if (ctrl_wr && sfr_wdata[`LNC_CTRL_STOP]) begin
							dreq_q <= 1'b0;
							state_q <= S_IDLE;
						end else if (ctrl_wr && sfr_wdata[`LNC_CTRL_DACK]) begin
							dreq_q <= 1'b0;
							resp_tx_q <= sfr_wdata[`LNC_CTRL_TXRX];
							phase_q <= P_DATA;
							byte_cnt_q <= 3'd0;
							cks_q <= cks0;
							launch(sfr_wdata[`LNC_CTRL_TXRX], data_q[0]);
						end
					end
					S_BYTE: begin
						if (bit_mid_v) begin
							if (is_tx_q && rx_lvl != lin_tx_q) begin
								fail(`LNC_ERR_BIT);
							end else if (bit_idx_q == 4'd0 && rx_lvl) begin
								state_q <= S_RXW; // glitch, not a start bit
							end else if (bit_idx_q == 4'd9 && !rx_lvl) begin
								fail(`LNC_ERR_FRM);
							end else if (bit_idx_q != 4'd0 && bit_idx_q != 4'd9) begin
								rxs_q <= {rx_lvl, rxs_q[7:1]};
							end
						end else if (bit_end_v && bit_idx_q != 4'd9) begin
							bit_idx_q <= bit_idx_q + 4'd1;
							lin_tx_q <= (bit_idx_q == 4'd8) | ~is_tx_q | shf_q[0];
							shf_q <= {1'b0, shf_q[7:1]};
						end else if (bit_end_v) begin
							case (phase_q)
								P_SYNC: begin
									phase_q <= P_ID;
									if (master) begin
										launch(1'b1, f_pid(id_q));
									end else if (rxs_q == `LNC_SYNC_BYTE) begin
										launch(1'b0, 8'h00);
									end else begin
										fail(`LNC_ERR_SYNC);
									end
								end
								P_ID: begin
									if (master) begin
										phase_q <= P_DATA;
										byte_cnt_q <= 3'd0;
										cks_q <= cks0;
										launch(resp_tx_q, data_q[0]);
									end else if (rxs_q != f_pid(rxs_q[5:0])) begin
										fail(`LNC_ERR_PAR);
									end else begin
										id_q <= rxs_q[5:0];
										dreq_q <= 1'b1;
										int_q <= 1'b1;
										state_q <= S_WACK;
									end
								end
								P_DATA: begin
									cks_q <= sum_now;
									byte_cnt_q <= nxt;
									if (!resp_tx_q) begin
										data_q[byte_cnt_q] <= rxs_q;
									end
									if ({1'b0, nxt} == len || byte_cnt_q == 3'd7) begin
										phase_q <= P_CKS;
										launch(resp_tx_q, ~sum_now);
									end else begin
										launch(resp_tx_q, data_q[nxt]);
									end
								end
								default: begin
									if (rxs_q == ~cks_q) begin
										done_q <= 1'b1;
										int_q <= 1'b1;
										state_q <= S_IDLE;
									end else begin
										fail(`LNC_ERR_CKS);
									end
								end
							endcase
						end
					end
					default: state_q <= S_IDLE;
				endcase
			end
		end
	end
endmodule

// [verif/lnc_checker.sv]
`timescale 1ns/10ps
// watches the register port and bus pins of the node controller
module lnc_checker #(
	parameter DIV_W = 9
) (
	// clock and reset
	input wire ref_clk,
	input wire resetn,
	// direct register port
	input wire [1:0] sfr_addr,
	input wire sfr_wr,
	input wire [7:0] sfr_wdata,
	input wire [7:0] sfr_rdata_q,
	// bus pins and interrupt
	input wire lin_rx,
	input wire lin_tx_q,
	input wire irq_q
);
	// ****************************************
	// shadow of the software-visible setup
	// ****************************************
	reg [7:0] idx_q; // index as last written
	reg [7:0] conf_q; // configuration, enable kept sticky
	reg [7:0] fac_q; // rate factors register
	reg [7:0] dl_q; // divider low register
	integer low_q; // length of the current low run on tx
	wire [31:0] bit_t; // bit period in clocks
	wire win_wr; // write through the window

	assign win_wr = sfr_wr && sfr_addr == 2'h2;
	// divider width follows the design parameter
	assign bit_t = (2 << fac_q[7:6]) * {fac_q[0], dl_q[DIV_W-2:0]} * (fac_q[5:1] + 1);

	// shadows update on the same edge as the design registers
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			idx_q <= 8'h00;
			conf_q <= 8'h00;
			fac_q <= 8'h00;
			dl_q <= 8'h00;
			low_q <= 0;
		end else begin
			if (sfr_wr && sfr_addr == 2'h1) begin
				idx_q <= sfr_wdata;
			end
			// only reset clears the enable
			if (sfr_wr && sfr_addr == 2'h0) begin
				conf_q <= {conf_q[7] | sfr_wdata[7], sfr_wdata[6:0]};
			end
			if (win_wr && idx_q == 8'h0D) begin
				fac_q <= sfr_wdata;
			end
			if (win_wr && idx_q == 8'h0C) begin
				dl_q <= sfr_wdata;
			end
			low_q <= lin_tx_q ? 0 : low_q + 1;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	// ****************************************
	// properties
	// ****************************************
	AST_RESET_IDLE: assert property (
		$rose(resetn) |-> lin_tx_q && !irq_q && sfr_rdata_q == 8'h00)
		else $error("outputs not idle after reset");
	AST_NO_ADDR_ZERO: assert property (
		sfr_addr == 2'h3 |=> sfr_rdata_q == 8'h00)
		else $error("unused direct address read nonzero");
	AST_INDEX_READBACK: assert property (
		(sfr_wr && sfr_addr == 2'h1) ##1 (!sfr_wr && sfr_addr == 2'h1)
		|=> sfr_rdata_q == $past(sfr_wdata, 2))
		else $error("index readback wrong");
	AST_CONF_READBACK: assert property (
		(sfr_wr && sfr_addr == 2'h0) ##1 (!sfr_wr && sfr_addr == 2'h0)
		|=> sfr_rdata_q[6:0] == $past(sfr_wdata[6:0], 2))
		else $error("configuration readback wrong");
	AST_FACTOR_READBACK: assert property (
		sfr_addr == 2'h2 && (idx_q == 8'h0C || idx_q == 8'h0D)
		|=> sfr_rdata_q == ($past(idx_q[0]) ? $past(fac_q) : $past(dl_q)))
		else $error("rate register readback wrong");
	AST_UNMAPPED_ZERO: assert property (
		sfr_addr == 2'h2 && idx_q > 8'h0E |=> sfr_rdata_q == 8'h00)
		else $error("unmapped index read nonzero");
	AST_IDLE_WHEN_OFF: assert property (
		!conf_q[7] |-> lin_tx_q)
		else $error("bus driven while disabled");
	AST_START_BREAK: assert property (
		win_wr && idx_q == 8'h08 && sfr_wdata[0] && conf_q[7:6] == 2'b11 && lin_tx_q
		&& !irq_q |-> ##2 !lin_tx_q)
		else $error("start did not begin a break");
	AST_BREAK_LENGTH: assert property (
		$rose(lin_tx_q) |-> low_q <= 9 * bit_t || low_q == 13 * bit_t)
		else $error("low run is neither a byte nor a break");
	AST_IRQ_CLEAR: assert property (
		win_wr && idx_q == 8'h08 && sfr_wdata[3] |-> ##2 !irq_q)
		else $error("interrupt not cleared");
endmodule

// [verif/lnc_bus_peer.sv]
`timescale 1ns/10ps
// other node on the single wire: pull-up idle, wired-and of the drivers
module lnc_bus_peer (
	// our transmit pin and a command to hold the wire dominant
	node_tx,
	jam,
	// level seen on the wire
	bus
);
	input wire node_tx;
	input wire jam;
	output wire bus;
	// a jam is the only misbehaviour, used to provoke a readback error
	assign bus = node_tx & ~jam;
endmodule

// [verif/lnc_testbench.sv]
`timescale 1ns/10ps
module testbench;
	// ****************************************
	// stimulus and observed signals
	// ****************************************
	reg ref_clk = 1'b0;
	reg resetn = 1'b0;
	reg [1:0] sfr_addr = 2'h0;
	reg sfr_wr = 1'b0;
	reg [7:0] sfr_wdata = 8'h00;
	reg jam = 1'b0; // peer forces dominant
	wire [7:0] sfr_rdata_q;
	wire lin_tx_q;
	wire irq_q;
	wire lin_rx;
	integer errors = 0;
	integer checks_done = 0;
	reg [7:0] v;

	lnc_top #(.DIV_W(9)) dut (.ref_clk(ref_clk), .resetn(resetn), .sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q),
		.lin_rx(lin_rx), .lin_tx_q(lin_tx_q), .irq_q(irq_q));
	lnc_bus_peer peer (.node_tx(lin_tx_q), .jam(jam), .bus(lin_rx));

	// 20 MHz
	always #25 ref_clk = ~ref_clk;

	// ****************************************
	// access tasks
	// ****************************************
	task finish_test;
		begin
			$display("errors %0d checks %0d", errors, checks_done);
			if (errors == 0 && checks_done > 0) begin
				$display("Finished cleanly");
			end else begin
				$display("Finished with errors");
			end
			$finish;
		end
	endtask
	task check(input [31:0] seen, input [31:0] exp);
		begin
			checks_done = checks_done + 1;
			if (seen !== exp) begin
				errors = errors + 1;
				$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	// every task leaves time just after a rising edge
	task cyc(input integer n);
		begin
			repeat (n) @(posedge ref_clk);
			#1;
		end
	endtask
	// strobe drops one edge later so the next write never lands in the same step
	task wr(input [1:0] a, input [7:0] d);
		begin
			sfr_addr = a;
			sfr_wdata = d;
			sfr_wr = 1'b1;
			cyc(1);
			sfr_wr = 1'b0;
			cyc(1);
		end
	endtask
	task rd(input [1:0] a, output [7:0] q);
		begin
			sfr_addr = a;
			cyc(1);
			q = sfr_rdata_q;
		end
	endtask
	task wi(input [7:0] ix, input [7:0] d);
		begin
			wr(2'h1, ix);
			wr(2'h2, d);
		end
	endtask
	task ri(input [7:0] ix, output [7:0] q);
		begin
			wr(2'h1, ix);
			rd(2'h2, q);
		end
	endtask
	// counts cycles until tx shows level b, bounded by lim
	task wait_tx(input b, input integer lim, output integer n);
		begin
			n = 0;
			while (lin_tx_q !== b && n < lim) begin
				n = n + 1;
				cyc(1);
			end
		end
	endtask

	// master frame with id 0x11 and one data byte; jm jams the wire
	task frame(input [1:0] pre, input [4:0] mul, input [8:0] dv, input [7:0] sz,
		input [7:0] ck, input jm);
		integer t, n, i, k;
		reg [7:0] b;
		reg [31:0] exp;
		begin
			t = (2 << pre) * dv * (mul + 1);
			exp = {ck, 8'h41, 8'h11, 8'h55};
			wi(8'h0D, {pre, mul, dv[8]});
			wi(8'h0C, dv[7:0]);
			ri(8'h0D, b); check(b, {pre, mul, dv[8]});
			ri(8'h0C, b); check(b, dv[7:0]);
			wi(8'h0B, sz);
			wi(8'h0E, 8'h11);
			wi(8'h00, 8'h41);
			wi(8'h08, 8'h20);
			// start keeps the transmit direction, since each control write sets it
			sfr_addr = 2'h2;
			sfr_wdata = 8'h21;
			sfr_wr = 1'b1;
			cyc(1);
			sfr_wr = 1'b0;
			jam = jm;
			wait_tx(1'b0, 3, n);
			wait_tx(1'b1, 20 * t, n); check(n, 13 * t);
			wait_tx(1'b0, 2 * t, n); check(n, t);
			// sample each bit near its middle, lsb first
			for (i = 0; i < 4 && !jm; i = i + 1) begin
				wait_tx(1'b0, 20 * t, n);
				cyc(t / 2 + t);
				for (k = 0; k < 8; k = k + 1) begin
					b[k] = lin_tx_q;
					cyc(t);
				end
				check(lin_tx_q, 1'b1);
				check(b, exp[8*i +: 8]);
			end
			n = 0;
			while (irq_q !== 1'b1 && n < 60 * t) begin
				n = n + 1;
				cyc(1);
			end
			jam = 1'b0;
			check(irq_q, 1'b1);
			ri(8'h09, b); check(b & (jm ? 8'h0C : 8'h0D), jm ? 8'h0C : 8'h09);
			ri(8'h0A, b); check(b[0], jm);
			wi(8'h08, 8'h0C); check(irq_q, 1'b0);
			ri(8'h09, b); check(b & 8'h0D, 8'h00);
			$display("frame test done, bit time %0d", t);
		end
	endtask

	// ****************************************
	// test sequence
	// ****************************************
	initial begin
		repeat (6) @(posedge ref_clk);
		#1;
		resetn = 1'b1;
		check(lin_tx_q, 1'b1);
		check(irq_q, 1'b0);
		rd(2'h0, v); check(v, 8'h00);
		rd(2'h3, v); check(v, 8'h00);
		ri(8'h08, v); check(v, 8'h00);
		$display("reset test done");
		wi(8'h30, 8'h5A); ri(8'h30, v); check(v, 8'h00);
		wi(8'h09, 8'hFF); ri(8'h09, v); check(v, 8'h00);
		wi(8'h0D, 8'hFF); ri(8'h0D, v); check(v, 8'hFF);
		wi(8'h0B, 8'h8F); ri(8'h0B, v); check(v, 8'h8F);
		rd(2'h1, v); check(v, 8'h0B);
		$display("register test done");
		// a start while disabled must leave the wire recessive
		wi(8'h08, 8'h01);
		cyc(4); check(lin_tx_q, 1'b1);
		// master role with manual rate only
		wr(2'h0, 8'h80);
		wr(2'h0, 8'h40);
		rd(2'h0, v); check(v, 8'hC0);
		$display("configuration test done");
		// classic sum, then enhanced sum with other factors, then a jammed frame;
		// a bit must outlast the receive catcher's delay, so no bit under 10 clocks
		frame(2'h0, 5'h00, 9'h006, 8'h01, 8'hBE, 1'b0);
		frame(2'h1, 5'h01, 9'h003, 8'h81, 8'hAD, 1'b0);
		frame(2'h0, 5'h00, 9'h006, 8'h01, 8'hBE, 1'b1);
		finish_test;
	end

	// the whole run needs well under 10000 cycles
	initial begin
		#2000000;
		errors = errors + 1;
		finish_test;
	end
endmodule

bind lnc_top lnc_checker #(.DIV_W(DIV_W)) chk (.ref_clk(ref_clk), .resetn(resetn),
	.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q),
	.lin_rx(lin_rx), .lin_tx_q(lin_tx_q), .irq_q(irq_q));
